// [src/qps_status_top.sv]
// questionable status group with its power sub-group
`timescale 1ns/100ps
`default_nettype none

// Operation
// - power condition follows hardware live; writes to it are ignored
// - each bit has own rising and falling edge mask
// - power event bits latch selected edges and hold until cleared
// - questionable event bits latch selected edges and hold likewise
// - reading an event register returns it and clears it at once
// - questionable enable gates events into status byte bit 3
// - power enable gates events into questionable condition bit 3
// - enable masks are written as values and read back exactly
// - power bit 0 set while reverse power guard tripped, RF off
// - trip holds until protection clear command, then bit 0 drops if the trip input is low
// - RF output driven off whenever guard is tripped
// - power bit 1 set while leveling loop cannot reach power
// - power bit 2 set while modulator input level is too high
// - power bit 4 set while leveling detector is still cold
// - power bits 3 and 5 through 15 always read zero
// - questionable bit 3 carries the power summary
// - questionable bit 9 flags self-test failure, cleared only by reset
module qps_status_top (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic TRIP_DETECT,
  input wire logic UNLEVELED,
  input wire logic MOD_OVERDRIVE,
  input wire logic DETECTOR_COLD,
  input wire logic SELFTEST_FAIL,
  input wire logic CMD_VALID,
  input wire logic CMD_WRITE,
  input wire logic [3:0] CMD_SEL,
  input wire logic [15:0] CMD_WDATA,
  input wire logic PROT_CLEAR_CMD,
  input wire logic CLEAR_STATUS_CMD,
  output logic RSP_VALID,
  output logic [15:0] RSP_DATA,
  output logic RF_OUTPUT_OFF,
  output logic POWER_SUMMARY,
  output logic [7:0] STATUS_BYTE
);

  logic [qps_pkg::PIN_COUNT-1:0] sync_a_reg;
  logic [qps_pkg::PIN_COUNT-1:0] sync_b_reg;
  logic trip_reg;
  logic selftest_reg;
  logic [15:0] pow_cond;
  logic [15:0] ques_cond;
  logic [15:0] pow_ptr_reg;
  logic [15:0] pow_ntr_reg;
  logic [15:0] pow_en_reg;
  logic [15:0] pow_en_next;
  logic [15:0] ques_ptr_reg;
  logic [15:0] ques_ntr_reg;
  logic [15:0] ques_en_reg;
  logic [15:0] ques_en_next;
  logic [15:0] pow_event;
  logic [15:0] pow_event_next;
  logic [15:0] ques_event;
  logic [15:0] ques_event_next;
  logic pow_set_any;
  logic pow_clear;
  logic ques_clear;
  logic rd_cmd;
  logic [15:0] rd_mux;
  function automatic logic wr_hit(input logic [3:0] sel_code,
    input logic valid, input logic write, input logic [3:0] sel);
    wr_hit = valid && write && (sel == sel_code);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      sync_a_reg <= '0;
      sync_b_reg <= '0;
    end
    else
    begin
      sync_a_reg <= {SELFTEST_FAIL, DETECTOR_COLD, MOD_OVERDRIVE,
                     UNLEVELED, TRIP_DETECT};
      sync_b_reg <= sync_a_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reverse power guard and self-test flag
  // trip holds until cleared, output off
  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      trip_reg <= 1'b0;
      RF_OUTPUT_OFF <= 1'b0;
    end
    else
    begin
      trip_reg <= sync_b_reg[qps_pkg::PIN_TRIP] |
                  (trip_reg & ~PROT_CLEAR_CMD);
      RF_OUTPUT_OFF <= sync_b_reg[qps_pkg::PIN_TRIP] |
                       (trip_reg & ~PROT_CLEAR_CMD);
    end
  end
  // status clear never touches this flag
  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
      selftest_reg <= 1'b0;
    else
      selftest_reg <= selftest_reg | sync_b_reg[qps_pkg::PIN_SELFTEST];
  end

  ////////////////////////////////////////////////////////////////////////////
  // condition vectors
  // live power condition
  always_comb
  begin
    pow_cond = '0;
    pow_cond[qps_pkg::POW_TRIP_BIT] = trip_reg;
    pow_cond[qps_pkg::POW_UNLEVEL_BIT] = sync_b_reg[qps_pkg::PIN_UNLEVEL];
    pow_cond[qps_pkg::POW_OVERDRIVE_BIT] =
      sync_b_reg[qps_pkg::PIN_OVERDRIVE];
    pow_cond[qps_pkg::POW_COLD_BIT] = sync_b_reg[qps_pkg::PIN_COLD];
  end
  // power summary into questionable bit 3
  always_comb
  begin
    ques_cond = '0;
    ques_cond[qps_pkg::QUES_POWER_BIT] = POWER_SUMMARY;
    ques_cond[qps_pkg::QUES_SELFTEST_BIT] = selftest_reg;
  end

  ////////////////////////////////////////////////////////////////////////////
  // writable masks
  // edge masks of both groups
  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      pow_ptr_reg <= qps_pkg::PTR_RESET;
      pow_ntr_reg <= qps_pkg::NTR_RESET;
      ques_ptr_reg <= qps_pkg::PTR_RESET;
      ques_ntr_reg <= qps_pkg::NTR_RESET;
    end
    else
    begin
      if (wr_hit(qps_pkg::SEL_POW_PTR, CMD_VALID, CMD_WRITE, CMD_SEL))
        pow_ptr_reg <= CMD_WDATA;
      if (wr_hit(qps_pkg::SEL_POW_NTR, CMD_VALID, CMD_WRITE, CMD_SEL))
        pow_ntr_reg <= CMD_WDATA;
      if (wr_hit(qps_pkg::SEL_QUES_PTR, CMD_VALID, CMD_WRITE, CMD_SEL))
        ques_ptr_reg <= CMD_WDATA;
      if (wr_hit(qps_pkg::SEL_QUES_NTR, CMD_VALID, CMD_WRITE, CMD_SEL))
        ques_ntr_reg <= CMD_WDATA;
    end
  end
  // enable masks store the written value
  always_comb
  begin
    pow_en_next = pow_en_reg;
    ques_en_next = ques_en_reg;
    if (wr_hit(qps_pkg::SEL_POW_ENABLE, CMD_VALID, CMD_WRITE, CMD_SEL))
      pow_en_next = CMD_WDATA;
    if (wr_hit(qps_pkg::SEL_QUES_ENABLE, CMD_VALID, CMD_WRITE, CMD_SEL))
      ques_en_next = CMD_WDATA;
  end
  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      pow_en_reg <= qps_pkg::ENABLE_RESET;
      ques_en_reg <= qps_pkg::ENABLE_RESET;
    end
    else
    begin
      pow_en_reg <= pow_en_next;
      ques_en_reg <= ques_en_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // event latches
  // clear on read or on status clear
  always_comb
  begin
    rd_cmd = CMD_VALID && !CMD_WRITE;
    pow_clear = CLEAR_STATUS_CMD ||
                (rd_cmd && CMD_SEL == qps_pkg::SEL_POW_EVENT);
    ques_clear = CLEAR_STATUS_CMD ||
                 (rd_cmd && CMD_SEL == qps_pkg::SEL_QUES_EVENT);
  end

  qps_edge_latch #(.W(qps_pkg::REG_W)) u_pow_latch (
    .clk(CLK_SYS),
    .rst(RST),
    .cond(pow_cond),
    .ptr(pow_ptr_reg),
    .ntr(pow_ntr_reg),
    .clear(pow_clear),
    .event_q(pow_event),
    .event_next(pow_event_next),
    .set_any(pow_set_any)
  );
  qps_edge_latch #(.W(qps_pkg::REG_W)) u_ques_latch (
    .clk(CLK_SYS),
    .rst(RST),
    .cond(ques_cond),
    .ptr(ques_ptr_reg),
    .ntr(ques_ntr_reg),
    .clear(ques_clear),
    .event_q(ques_event),
    .event_next(ques_event_next),
    .set_any()
  );

  ////////////////////////////////////////////////////////////////////////////
  // summaries, built from next values so they move with their operands
  // power summary
  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
      POWER_SUMMARY <= 1'b0;
    else
      POWER_SUMMARY <= |(pow_event_next & pow_en_next);
  end
  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
      STATUS_BYTE <= '0;
    else
    begin
      STATUS_BYTE <= '0;
      STATUS_BYTE[qps_pkg::STB_QUES_BIT] <= |(ques_event_next & ques_en_next);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read response
  // condition registers have no write path
  always_comb
  begin
    unique case (CMD_SEL)
      qps_pkg::SEL_QUES_COND: rd_mux = ques_cond;
      qps_pkg::SEL_QUES_EVENT: rd_mux = ques_event;
      qps_pkg::SEL_QUES_ENABLE: rd_mux = ques_en_reg;
      qps_pkg::SEL_QUES_PTR: rd_mux = ques_ptr_reg;
      qps_pkg::SEL_QUES_NTR: rd_mux = ques_ntr_reg;
      qps_pkg::SEL_POW_COND: rd_mux = pow_cond;
      qps_pkg::SEL_POW_PTR: rd_mux = pow_ptr_reg;
      qps_pkg::SEL_POW_NTR: rd_mux = pow_ntr_reg;
      qps_pkg::SEL_POW_EVENT: rd_mux = pow_event;
      qps_pkg::SEL_POW_ENABLE: rd_mux = pow_en_reg;
      default: rd_mux = '0;
    endcase
  end
  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      RSP_VALID <= 1'b0;
      RSP_DATA <= '0;
    end
    else
    begin
      RSP_VALID <= rd_cmd;
      RSP_DATA <= rd_cmd ? rd_mux : 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  property p_pow_reserved;
    pow_cond[15:5] == 11'h000 && !pow_cond[3];
  endproperty
  a_pow_reserved: assert property (p_pow_reserved)
    else $error("reserved power condition bit set");
  property p_trip_off;
    $rose(sync_b_reg[qps_pkg::PIN_TRIP]) |=> RF_OUTPUT_OFF && pow_cond[0];
  endproperty
  a_trip_off: assert property (p_trip_off)
    else $error("trip did not turn output off");
  property p_trip_hold;
    trip_reg && !PROT_CLEAR_CMD |=> trip_reg && RF_OUTPUT_OFF;
  endproperty
  a_trip_hold: assert property (p_trip_hold)
    else $error("trip released without clear");
  property p_trip_clear;
    PROT_CLEAR_CMD && !sync_b_reg[qps_pkg::PIN_TRIP] |=>
      !pow_cond[0] && !RF_OUTPUT_OFF;
  endproperty
  a_trip_clear: assert property (p_trip_clear)
    else $error("protection clear did not reset trip");
  property p_read_clear;
    rd_cmd && CMD_SEL == qps_pkg::SEL_POW_EVENT && !pow_set_any |=>
      pow_event == 16'h0000 && RSP_VALID && RSP_DATA == $past(pow_event);
  endproperty
  a_read_clear: assert property (p_read_clear)
    else $error("event read did not return and clear");
  property p_pow_sum;
    POWER_SUMMARY == |(pow_event & pow_en_reg);
  endproperty
  a_pow_sum: assert property (p_pow_sum)
    else $error("power summary mismatch");
  property p_ques_sum;
    STATUS_BYTE[3] == |(ques_event & ques_en_reg) && ques_cond[3] ==
      POWER_SUMMARY;
  endproperty
  a_ques_sum: assert property (p_ques_sum)
    else $error("questionable summary mismatch");
  property p_en_readback;
    wr_hit(qps_pkg::SEL_POW_ENABLE, CMD_VALID, CMD_WRITE, CMD_SEL) |=>
      pow_en_reg == $past(CMD_WDATA);
  endproperty
  a_en_readback: assert property (p_en_readback)
    else $error("enable mask not stored");
  property p_selftest_keep;
    selftest_reg |=> ques_cond[9];
  endproperty
  a_selftest_keep: assert property (p_selftest_keep)
    else $error("self-test flag cleared");

  c_trip_clear: cover property (trip_reg ##1 PROT_CLEAR_CMD ##1 !trip_reg);
  c_read_event: cover property (pow_event != 16'h0000 ##1
    rd_cmd && CMD_SEL == qps_pkg::SEL_POW_EVENT);
  c_ques_sum: cover property ($rose(STATUS_BYTE[3]));

endmodule

`default_nettype wire

// [src/qps_pkg.sv]
// shared constants for the questionable power status block
package qps_pkg;

  localparam int REG_W = 16;
  localparam int SEL_W = 4;
  localparam int STB_W = 8;

  // register select codes on the command port
  localparam logic [3:0] SEL_QUES_COND = 4'h0;
  localparam logic [3:0] SEL_QUES_EVENT = 4'h1;
  localparam logic [3:0] SEL_QUES_ENABLE = 4'h2;
  localparam logic [3:0] SEL_QUES_PTR = 4'h3;
  localparam logic [3:0] SEL_QUES_NTR = 4'h4;
  localparam logic [3:0] SEL_POW_COND = 4'h5;
  localparam logic [3:0] SEL_POW_PTR = 4'h6;
  localparam logic [3:0] SEL_POW_NTR = 4'h7;
  localparam logic [3:0] SEL_POW_EVENT = 4'h8;
  localparam logic [3:0] SEL_POW_ENABLE = 4'h9;

  // power condition bit positions
  localparam int POW_TRIP_BIT = 0;
  localparam int POW_UNLEVEL_BIT = 1;
  localparam int POW_OVERDRIVE_BIT = 2;
  localparam int POW_COLD_BIT = 4;

  // questionable condition bit positions
  localparam int QUES_POWER_BIT = 3;
  localparam int QUES_SELFTEST_BIT = 9;

  // status byte position of the questionable summary
  localparam int STB_QUES_BIT = 3;

  // input pin indices in the synchroniser vector
  localparam int PIN_TRIP = 0;
  localparam int PIN_UNLEVEL = 1;
  localparam int PIN_OVERDRIVE = 2;
  localparam int PIN_COLD = 3;
  localparam int PIN_SELFTEST = 4;
  localparam int PIN_COUNT = 5;

  // reset values
  localparam logic [15:0] PTR_RESET = 16'hFFFF;
  localparam logic [15:0] NTR_RESET = 16'h0000;
  localparam logic [15:0] ENABLE_RESET = 16'h0000;
  localparam logic [15:0] EVENT_RESET = 16'h0000;

endpackage

// [src/qps_edge_latch.sv]
// transition filter and clear-on-read event latch for one status group
`timescale 1ns/100ps
`default_nettype none

module qps_edge_latch #(
  parameter int W = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] cond,
  input wire logic [W-1:0] ptr,
  input wire logic [W-1:0] ntr,
  input wire logic clear,
  output logic [W-1:0] event_q,
  output logic [W-1:0] event_next,
  output logic set_any
);

  logic [W-1:0] prev_reg;
  logic [W-1:0] rise;
  logic [W-1:0] fall;
  logic [W-1:0] set_bits;

  ////////////////////////////////////////////////////////////////////////////
  // edge qualification

  always_ff @(posedge clk)
  begin
    if (rst)
      prev_reg <= '0;
    else
      prev_reg <= cond;
  end

  always_comb
  begin
    rise = cond & ~prev_reg & ptr;
    fall = ~cond & prev_reg & ntr;
    set_bits = rise | fall;
    set_any = |set_bits;
  end

  ////////////////////////////////////////////////////////////////////////////
  // event latch; a new event beats a clear in the same cycle

  always_comb
  begin
    event_next = (clear ? '0 : event_q) | set_bits;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      event_q <= '0;
    else
      event_q <= event_next;
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_rise_latch;
    (~event_q & $past(cond) & ~$past(cond, 2) & $past(ptr)) == '0;
  endproperty
  a_rise_latch: assert property (p_rise_latch)
    else $error("selected rising edge not latched");
  property p_fall_masked;
    (event_q & $past(~cond) & $past(cond, 2) & ~$past(ntr) &
      ~$past(event_q)) == '0;
  endproperty
  a_fall_masked: assert property (p_fall_masked)
    else $error("masked falling edge latched");
  property p_clear_empty;
    clear |=> (event_q & ~($past(cond) ^ $past(cond, 2))) == '0;
  endproperty
  a_clear_empty: assert property (p_clear_empty)
    else $error("event bits survived a clear");

endmodule

`default_nettype wire

// [sim/tb_qps_status_top.sv]
// self-checking testbench for the questionable power status block
`timescale 1ns/100ps
`default_nettype none

module tb_qps_status_top;
  logic CLK_SYS = 1'b0;
  logic RST = 1'b1;
  logic TRIP_DETECT = 1'b0;
  logic UNLEVELED = 1'b0;
  logic MOD_OVERDRIVE = 1'b0;
  logic DETECTOR_COLD = 1'b0;
  logic SELFTEST_FAIL = 1'b0;
  logic CMD_VALID = 1'b0;
  logic CMD_WRITE = 1'b0;
  logic [3:0] CMD_SEL = 4'h0;
  logic [15:0] CMD_WDATA = 16'h0000;
  logic PROT_CLEAR_CMD = 1'b0;
  logic CLEAR_STATUS_CMD = 1'b0;
  logic RSP_VALID;
  logic [15:0] RSP_DATA;
  logic RF_OUTPUT_OFF;
  logic POWER_SUMMARY;
  logic [7:0] STATUS_BYTE;
  int checks = 0;
  int bad_count = 0;

  always #25 CLK_SYS = ~CLK_SYS;

  qps_status_top qps_status_top_inst (
    .CLK_SYS(CLK_SYS),
    .RST(RST),
    .TRIP_DETECT(TRIP_DETECT),
    .UNLEVELED(UNLEVELED),
    .MOD_OVERDRIVE(MOD_OVERDRIVE),
    .DETECTOR_COLD(DETECTOR_COLD),
    .SELFTEST_FAIL(SELFTEST_FAIL),
    .CMD_VALID(CMD_VALID),
    .CMD_WRITE(CMD_WRITE),
    .CMD_SEL(CMD_SEL),
    .CMD_WDATA(CMD_WDATA),
    .PROT_CLEAR_CMD(PROT_CLEAR_CMD),
    .CLEAR_STATUS_CMD(CLEAR_STATUS_CMD),
    .RSP_VALID(RSP_VALID),
    .RSP_DATA(RSP_DATA),
    .RF_OUTPUT_OFF(RF_OUTPUT_OFF),
    .POWER_SUMMARY(POWER_SUMMARY),
    .STATUS_BYTE(STATUS_BYTE)
  );

  ////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge CLK_SYS);
  endtask

  task automatic wr(input logic [3:0] sel, input logic [15:0] d);
    @(posedge CLK_SYS);
    CMD_VALID <= 1'b1;
    CMD_WRITE <= 1'b1;
    CMD_SEL <= sel;
    CMD_WDATA <= d;
    @(posedge CLK_SYS);
    CMD_VALID <= 1'b0;
    CMD_WRITE <= 1'b0;
    #1;
  endtask

  // read answer is registered on the same edge that takes the request
  task automatic rdc(input logic [3:0] sel, input logic [15:0] exp);
    @(posedge CLK_SYS);
    CMD_VALID <= 1'b1;
    CMD_WRITE <= 1'b0;
    CMD_SEL <= sel;
    @(posedge CLK_SYS);
    CMD_VALID <= 1'b0;
    #1;
    chk({15'h0000, RSP_VALID}, 16'h0001);
    chk(RSP_DATA, exp);
  endtask

  // pins: selftest, cold, overdrive, unleveled, trip; allow sync delay
  task automatic pins(input logic [4:0] v);
    @(posedge CLK_SYS);
    {SELFTEST_FAIL, DETECTOR_COLD, MOD_OVERDRIVE, UNLEVELED, TRIP_DETECT} <= v;
    cyc(5);
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset_values;
    rdc(qps_pkg::SEL_POW_PTR, 16'hFFFF);
    rdc(qps_pkg::SEL_POW_NTR, 16'h0000);
    rdc(qps_pkg::SEL_QUES_PTR, 16'hFFFF);
    rdc(qps_pkg::SEL_QUES_NTR, 16'h0000);
    rdc(qps_pkg::SEL_POW_ENABLE, 16'h0000);
    rdc(qps_pkg::SEL_QUES_ENABLE, 16'h0000);
    rdc(qps_pkg::SEL_POW_EVENT, 16'h0000);
    rdc(4'hA, 16'h0000);
  endtask

  task automatic t_mask_rw;
    wr(qps_pkg::SEL_POW_ENABLE, 16'hA5C3);
    rdc(qps_pkg::SEL_POW_ENABLE, 16'hA5C3);
    wr(qps_pkg::SEL_QUES_ENABLE, 16'h0208);
    rdc(qps_pkg::SEL_QUES_ENABLE, 16'h0208);
    wr(qps_pkg::SEL_QUES_NTR, 16'h1234);
    rdc(qps_pkg::SEL_QUES_NTR, 16'h1234);
    wr(qps_pkg::SEL_QUES_NTR, 16'h0000);
    wr(qps_pkg::SEL_POW_COND, 16'hFFFF);
    rdc(qps_pkg::SEL_POW_COND, 16'h0000);
    wr(qps_pkg::SEL_POW_EVENT, 16'hFFFF);
    rdc(qps_pkg::SEL_POW_EVENT, 16'h0000);
    wr(4'hB, 16'hFFFF);
    rdc(4'hB, 16'h0000);
    wr(qps_pkg::SEL_POW_ENABLE, 16'h0000);
    wr(qps_pkg::SEL_QUES_ENABLE, 16'h0000);
  endtask

  task automatic t_levels;
    pins(5'b01110);
    rdc(qps_pkg::SEL_POW_COND, 16'h0016);
    wr(qps_pkg::SEL_POW_COND, 16'h0000);
    rdc(qps_pkg::SEL_POW_COND, 16'h0016);
    pins(5'b00000);
    rdc(qps_pkg::SEL_POW_COND, 16'h0000);
    rdc(qps_pkg::SEL_POW_EVENT, 16'h0016);
    rdc(qps_pkg::SEL_POW_EVENT, 16'h0000);
  endtask

  task automatic t_summary;
    wr(qps_pkg::SEL_POW_ENABLE, 16'h0002);
    pins(5'b00010);
    chk({15'h0000, POWER_SUMMARY}, 16'h0001);
    rdc(qps_pkg::SEL_QUES_COND, 16'h0008);
    chk({8'h00, STATUS_BYTE}, 16'h0000);
    wr(qps_pkg::SEL_QUES_ENABLE, 16'h0008);
    chk({8'h00, STATUS_BYTE}, 16'h0008);
    rdc(qps_pkg::SEL_POW_EVENT, 16'h0002);
    chk({15'h0000, POWER_SUMMARY}, 16'h0000);
    rdc(qps_pkg::SEL_QUES_EVENT, 16'h0008);
    chk({8'h00, STATUS_BYTE}, 16'h0000);
  endtask

  task automatic t_falling;
    wr(qps_pkg::SEL_POW_PTR, 16'h0000);
    wr(qps_pkg::SEL_POW_NTR, 16'h0002);
    pins(5'b00000);
    chk({15'h0000, POWER_SUMMARY}, 16'h0001);
    rdc(qps_pkg::SEL_POW_EVENT, 16'h0002);
    pins(5'b00010);
    rdc(qps_pkg::SEL_POW_EVENT, 16'h0000);
    rdc(qps_pkg::SEL_QUES_EVENT, 16'h0008);
    wr(qps_pkg::SEL_POW_PTR, 16'hFFFF);
    wr(qps_pkg::SEL_POW_NTR, 16'h0000);
    wr(qps_pkg::SEL_POW_ENABLE, 16'h0000);
    wr(qps_pkg::SEL_QUES_ENABLE, 16'h0000);
    pins(5'b00000);
  endtask

  task automatic t_trip;
    pins(5'b00001);
    pins(5'b00000);
    chk({15'h0000, RF_OUTPUT_OFF}, 16'h0001);
    rdc(qps_pkg::SEL_POW_COND, 16'h0001);
    cyc(20);
    #1;
    chk({15'h0000, RF_OUTPUT_OFF}, 16'h0001);
    @(posedge CLK_SYS);
    PROT_CLEAR_CMD <= 1'b1;
    @(posedge CLK_SYS);
    PROT_CLEAR_CMD <= 1'b0;
    #1;
    chk({15'h0000, RF_OUTPUT_OFF}, 16'h0000);
    rdc(qps_pkg::SEL_POW_COND, 16'h0000);
    rdc(qps_pkg::SEL_POW_EVENT, 16'h0001);
  endtask

  task automatic t_selftest;
    pins(5'b10000);
    pins(5'b00000);
    rdc(qps_pkg::SEL_QUES_COND, 16'h0200);
    @(posedge CLK_SYS);
    CLEAR_STATUS_CMD <= 1'b1;
    @(posedge CLK_SYS);
    CLEAR_STATUS_CMD <= 1'b0;
    rdc(qps_pkg::SEL_QUES_COND, 16'h0200);
    rdc(qps_pkg::SEL_QUES_EVENT, 16'h0000);
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    cyc(16);
    RST <= 1'b0;
    t_reset_values();
    t_mask_rw();
    t_levels();
    t_summary();
    t_falling();
    t_trip();
    t_selftest();
    cyc(4);
    tally_and_finish();
  end

  // hang guard
  initial
  begin
    #(50 * 40000);
    bad_count++;
    tally_and_finish();
  end
endmodule

`default_nettype wire
